// ---- rtl/logger_rtc_pkg.sv ----
// Package holding register map, field layout and timing constants of the logger clock page.
package logger_rtc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [9:0] OFS_SECONDS    = 10'h200;
    localparam logic [9:0] OFS_MINUTES    = 10'h201;
    localparam logic [9:0] OFS_HOURS      = 10'h202;
    localparam logic [9:0] OFS_WEEKDAY    = 10'h203;
    localparam logic [9:0] OFS_DATE       = 10'h204;
    localparam logic [9:0] OFS_MONTHS     = 10'h205;
    localparam logic [9:0] OFS_YEARS      = 10'h206;
    localparam logic [9:0] OFS_ALM_SEC    = 10'h207;
    localparam logic [9:0] OFS_ALM_MIN    = 10'h208;
    localparam logic [9:0] OFS_ALM_HOUR   = 10'h209;
    localparam logic [9:0] OFS_ALM_WDAY   = 10'h20A;
    localparam logic [9:0] OFS_TEMP_LOW   = 10'h20B;
    localparam logic [9:0] OFS_TEMP_HIGH  = 10'h20C;
    localparam logic [9:0] OFS_SAMPLE     = 10'h20D;
    localparam logic [9:0] OFS_CONTROL    = 10'h20E;

    // ------------------------------------------------------------------
    // Read masks of fixed-zero bits
    // ------------------------------------------------------------------
    localparam logic [7:0] MASK_SECONDS   = 8'h7F;
    localparam logic [7:0] MASK_MINUTES   = 8'h7F;
    localparam logic [7:0] MASK_HOURS     = 8'h7F;
    localparam logic [7:0] MASK_WEEKDAY   = 8'h07;
    localparam logic [7:0] MASK_DATE      = 8'h3F;
    localparam logic [7:0] MASK_MONTHS    = 8'h9F;
    localparam logic [7:0] MASK_ALM_WDAY  = 8'h87;
    localparam logic [7:0] MASK_CONTROL   = 8'hDF;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int HOUR_MODE_BIT  = 6;
    localparam int HOUR_PM_BIT    = 5;
    localparam int CENTURY_BIT    = 7;
    localparam int ALARM_MASK_BIT = 7;
    localparam int CTL_OSC_DIS    = 7;
    localparam int CTL_WIPE_ARM   = 6;
    localparam int CTL_MISSION_N  = 4;
    localparam int CTL_WRAP       = 3;
    localparam int CTL_LOW_SRCH   = 2;
    localparam int CTL_HIGH_SRCH  = 1;
    localparam int CTL_TIMER_SRCH = 0;

    // ------------------------------------------------------------------
    // BCD limits and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] BCD_59       = 8'h59;
    localparam logic [7:0] BCD_23       = 8'h23;
    localparam logic [7:0] BCD_12       = 8'h12;
    localparam logic [7:0] BCD_01       = 8'h01;
    localparam logic [7:0] BCD_99       = 8'h99;
    localparam logic [7:0] BCD_00       = 8'h00;
    localparam logic [7:0] WEEKDAY_LAST = 8'h07;
    localparam logic [7:0] FEB          = 8'h02;
    localparam logic [7:0] RST_CONTROL  = 8'h10;
    localparam logic [7:0] TEMP_UNDER   = 8'h00;
    localparam logic [7:0] TEMP_OVER    = 8'hFF;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLOCK_HZ     = 25_000_000;
    localparam int SECOND_MS    = 1000;
    localparam int SECOND_TICKS = CLOCK_HZ / 1000 * SECOND_MS;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] seconds;
        logic [7:0] minutes;
        logic [7:0] hours;
        logic [7:0] weekday;
        logic [7:0] date;
        logic [7:0] months;
        logic [7:0] years;
    } clock_regs_t;

    typedef struct packed {
        logic [7:0] seconds;
        logic [7:0] minutes;
        logic [7:0] hours;
        logic [7:0] weekday;
    } alarm_regs_t;

    typedef struct packed {
        logic       valid;
        logic       under;
        logic       over;
        logic [7:0] code;
    } temp_sample_t;

endpackage : logger_rtc_pkg

// ---- rtl/logger_rtc_alarm_config.sv ----
// Clock, calendar, time alarm and configuration register page of the temperature logger.
`timescale 1ns/1ns

// What this block does
// - Hours bit 6 chooses 12-hour counting when set, 24-hour when clear.
// - Hours bit 5 is PM flag in 12-hour mode, tens-of-twenty digit otherwise.
// - Weekday counts 1 through 7 and wraps; values carry no meaning.
// - February gets a 29th when the year is 00 or divisible by four.
// - Months bit 7 toggles whenever years roll from 99 to 00.
// - Time, calendar and alarm fields are stored as BCD digits.
// - Fixed-zero bits of the clock page always read as zero.
// - Bit 7 of each alarm register masks its field out of the compare.
// - All four masks set gives an alarm every second.
// - Clearing masks from seconds upward adds fields to the match.
// - All masks clear gives a weekly match on all four fields.
// - Each alarm sets the timer alarm flag.
// - With timer search enabled, a set alarm flag answers conditional search.
// - Temperatures are one unsigned byte in eighth degrees; 01h to FEh valid.
// - Under-range conversions store 00h, over-range store FFh.
// - Codes 04h to FBh are the specified range, bins 1 to 62.
// - Degrees are code/8 plus 14.5 or minus 5.5 depending on variant.
// - Low and high thresholds are full 8-bit registers in reading code.
// - Sample interval is minutes between conversions, 1 to 255.
// - Nonzero interval write starts a mission if cleared and enabled.
// - Control register is read-write; writing it during a mission ends it.
// - Control holds oscillator, wipe, mission, wrap and three search bits.
// - Control bit 5 always reads zero and ignores writes.
// - Oscillator disable set stops the clock; clear lets it run.
module logger_rtc_alarm_config
    import logger_rtc_pkg::*;
#(
    parameter int TICKS_PER_SECOND = SECOND_TICKS
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Register page access from the link controller
    input  wire logic         regWrite,
    input  wire logic         regRead,
    input  wire logic [9:0]   regAddr,
    input  wire logic [7:0]   regWdata,
    output      logic [7:0]   regRdata,
    output      logic         regRvalid,
    // Status inputs from the mission logic
    input  wire logic         clear_done_flag,
    input  wire logic         missionActive,
    input  wire logic         timerFlagClear,
    input  wire temp_sample_t tempIn,
    // Status and control outputs
    output      logic         timer_alarm_flag,
    output      logic         searchTimerMatch,
    output      logic         missionStart,
    output      logic         missionEnd,
    output      logic         oscillatorRunning,
    output      logic [7:0]   tempCode,
    output      logic         tempInRange,
    output      logic         wipe_arm,
    output      logic         wrap_logging_enable,
    output      logic         low_temp_search_enable,
    output      logic         high_temp_search_enable,
    output      logic [7:0]   lowThreshold,
    output      logic [7:0]   highThreshold,
    output      logic [7:0]   sampleInterval
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        clock_regs_t clk;
        alarm_regs_t alm;
        logic [7:0]  tempLow;
        logic [7:0]  tempHigh;
        logic [7:0]  sample;
        logic [7:0]  control;
        logic [31:0] prescale;
        logic        alarmFlag;
        logic        startPulse;
        logic        endPulse;
        logic [7:0]  rdata;
        logic        rvalid;
        logic [7:0]  tempCode;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // ------------------------------------------------------------------
    // BCD helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] bcdInc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcdInc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcdInc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcdInc

    function automatic logic [7:0] monthDays(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = ((yr[4] ? yr[3:0] + 4'h2 : yr[3:0]) % 4'h4) == 4'h0;
        case (mon)
            8'h04, 8'h06, 8'h09, 8'h11: monthDays = 8'h30;
            FEB:                        monthDays = leap ? 8'h29 : 8'h28;
            default:                    monthDays = 8'h31;
        endcase
    endfunction : monthDays

    // One step of the hours field in either format.
    function automatic logic [7:0] hourInc(input logic [7:0] h, output logic dayCarry);
        dayCarry = 1'b0;
        if (h[HOUR_MODE_BIT]) begin
            if (h[4:0] == 5'h11) begin
                hourInc = {h[7:6], ~h[HOUR_PM_BIT], 5'h12};
                dayCarry = h[HOUR_PM_BIT];
            end else if (h[4:0] == 5'h12) begin
                hourInc = {h[7:5], 5'h01};
            end else begin
                hourInc = {h[7:5], 5'(bcdInc({3'b000, h[4:0]}))};
            end
        end else if (h[5:0] == BCD_23[5:0]) begin
            hourInc = {h[7:6], 6'h00};
            dayCarry = 1'b1;
        end else begin
            hourInc = {h[7:6], 6'(bcdInc({2'b00, h[5:0]}))};
        end
    endfunction : hourInc

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic       secondTick;
    logic       carry;
    logic       alarmHit;
    logic [7:0] rd;

    always_comb begin
        state_next = state_reg;
        state_next.startPulse = 1'b0;
        state_next.endPulse = 1'b0;
        state_next.rvalid = 1'b0;
        carry = 1'b0;
        secondTick = 1'b0;
        alarmHit = 1'b0;
        rd = 8'h00;

        // Second prescaler stops while the oscillator is disabled.
        if (state_reg.control[CTL_OSC_DIS]) begin
            state_next.prescale = 32'h0000_0000;
        end else if (state_reg.prescale == 32'(TICKS_PER_SECOND - 1)) begin
            state_next.prescale = 32'h0000_0000;
            secondTick = 1'b1;
        end else begin
            state_next.prescale = state_reg.prescale + 32'h0000_0001;
        end

        // Time and calendar advance with BCD rollover.
        if (secondTick) begin
            if (state_reg.clk.seconds[6:0] == BCD_59[6:0]) begin
                state_next.clk.seconds = BCD_00;
                if (state_reg.clk.minutes[6:0] == BCD_59[6:0]) begin
                    state_next.clk.minutes = BCD_00;
                    state_next.clk.hours = hourInc(state_reg.clk.hours, carry);
                end else begin
                    state_next.clk.minutes = bcdInc(state_reg.clk.minutes & MASK_MINUTES);
                end
            end else begin
                state_next.clk.seconds = bcdInc(state_reg.clk.seconds & MASK_SECONDS);
            end
            if (carry) begin
                state_next.clk.weekday = (state_reg.clk.weekday[2:0] >= WEEKDAY_LAST[2:0])
                                         ? BCD_01 : bcdInc(state_reg.clk.weekday);
                if (state_reg.clk.date >= monthDays(state_reg.clk.months & 8'h1F, state_reg.clk.years)) begin
                    state_next.clk.date = BCD_01;
                    if ((state_reg.clk.months & 8'h1F) >= BCD_12) begin
                        state_next.clk.months = {state_reg.clk.months[CENTURY_BIT], 7'h01};
                        if (state_reg.clk.years == BCD_99) begin
                            state_next.clk.years = BCD_00;
                            state_next.clk.months[CENTURY_BIT] = ~state_reg.clk.months[CENTURY_BIT];
                        end else begin
                            state_next.clk.years = bcdInc(state_reg.clk.years);
                        end
                    end else begin
                        state_next.clk.months = {state_reg.clk.months[CENTURY_BIT], 2'b00,
                                                 5'(bcdInc(state_reg.clk.months & 8'h1F))};
                    end
                end else begin
                    state_next.clk.date = bcdInc(state_reg.clk.date);
                end
            end

            // Masked time-of-day compare; all masks set hits every second.
            alarmHit = (state_reg.alm.seconds[ALARM_MASK_BIT]
                        || state_next.clk.seconds == (state_reg.alm.seconds & MASK_SECONDS))
                    && (state_reg.alm.minutes[ALARM_MASK_BIT]
                        || state_next.clk.minutes == (state_reg.alm.minutes & MASK_MINUTES))
                    && (state_reg.alm.hours[ALARM_MASK_BIT]
                        || state_next.clk.hours == (state_reg.alm.hours & MASK_HOURS))
                    && (state_reg.alm.weekday[ALARM_MASK_BIT]
                        || state_next.clk.weekday == (state_reg.alm.weekday & MASK_WEEKDAY));
        end

        // Register writes; the fixed-zero bits are never stored.
        if (regWrite) begin
            case (regAddr)
                OFS_SECONDS: state_next.clk.seconds = regWdata & MASK_SECONDS;
                OFS_MINUTES: state_next.clk.minutes = regWdata & MASK_MINUTES;
                OFS_HOURS:   state_next.clk.hours   = regWdata & MASK_HOURS;
                OFS_WEEKDAY: state_next.clk.weekday = regWdata & MASK_WEEKDAY;
                OFS_DATE:    state_next.clk.date    = regWdata & MASK_DATE;
                OFS_MONTHS:  state_next.clk.months  = regWdata & MASK_MONTHS;
                OFS_YEARS:   state_next.clk.years   = regWdata;
                OFS_ALM_SEC: state_next.alm.seconds = regWdata;
                OFS_ALM_MIN: state_next.alm.minutes = regWdata;
                OFS_ALM_HOUR: state_next.alm.hours  = regWdata;
                OFS_ALM_WDAY: state_next.alm.weekday = regWdata & MASK_ALM_WDAY;
                OFS_TEMP_LOW:  state_next.tempLow  = regWdata;
                OFS_TEMP_HIGH: state_next.tempHigh = regWdata;
                OFS_SAMPLE: begin
                    state_next.sample = regWdata;
                    if (regWdata != BCD_00 && clear_done_flag
                        && !state_reg.control[CTL_MISSION_N] && !missionActive) begin
                        state_next.startPulse = 1'b1;
                    end
                end
                OFS_CONTROL: begin
                    state_next.control = regWdata & MASK_CONTROL;
                    state_next.endPulse = missionActive;
                end
                default: ;
            endcase
        end

        // Alarm flag: a new alarm wins over a clear in the same cycle.
        if (alarmHit) begin
            state_next.alarmFlag = 1'b1;
        end else if (timerFlagClear) begin
            state_next.alarmFlag = 1'b0;
        end

        // Conversion result clamped to the out-of-range codes.
        if (tempIn.valid) begin
            state_next.tempCode = tempIn.under ? TEMP_UNDER : (tempIn.over ? TEMP_OVER : tempIn.code);
        end

        // Register read path.
        case (regAddr)
            OFS_SECONDS:   rd = state_reg.clk.seconds & MASK_SECONDS;
            OFS_MINUTES:   rd = state_reg.clk.minutes & MASK_MINUTES;
            OFS_HOURS:     rd = state_reg.clk.hours & MASK_HOURS;
            OFS_WEEKDAY:   rd = state_reg.clk.weekday & MASK_WEEKDAY;
            OFS_DATE:      rd = state_reg.clk.date & MASK_DATE;
            OFS_MONTHS:    rd = state_reg.clk.months & MASK_MONTHS;
            OFS_YEARS:     rd = state_reg.clk.years;
            OFS_ALM_SEC:   rd = state_reg.alm.seconds;
            OFS_ALM_MIN:   rd = state_reg.alm.minutes;
            OFS_ALM_HOUR:  rd = state_reg.alm.hours;
            OFS_ALM_WDAY:  rd = state_reg.alm.weekday & MASK_ALM_WDAY;
            OFS_TEMP_LOW:  rd = state_reg.tempLow;
            OFS_TEMP_HIGH: rd = state_reg.tempHigh;
            OFS_SAMPLE:    rd = state_reg.sample;
            OFS_CONTROL:   rd = state_reg.control & MASK_CONTROL;
            default:       rd = 8'h00;
        endcase
        if (regRead) begin
            state_next.rdata = rd;
            state_next.rvalid = 1'b1;
        end

        if (!rst_n) begin
            state_next = '0;
            state_next.clk.weekday = BCD_01;
            state_next.clk.date = BCD_01;
            state_next.clk.months = BCD_01;
            state_next.control = RST_CONTROL;
        end
    end

    always_ff @(posedge sys_clk) begin
        state_reg <= state_next;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign regRdata                = state_reg.rdata;
    assign regRvalid               = state_reg.rvalid;
    assign timer_alarm_flag        = state_reg.alarmFlag;
    assign searchTimerMatch        = state_reg.alarmFlag & state_reg.control[CTL_TIMER_SRCH];
    assign missionStart            = state_reg.startPulse;
    assign missionEnd              = state_reg.endPulse;
    assign oscillatorRunning       = ~state_reg.control[CTL_OSC_DIS];
    assign tempCode                = state_reg.tempCode;
    assign tempInRange             = state_reg.tempCode >= 8'h04 && state_reg.tempCode <= 8'hFB;
    assign wipe_arm                = state_reg.control[CTL_WIPE_ARM];
    assign wrap_logging_enable     = state_reg.control[CTL_WRAP];
    assign low_temp_search_enable  = state_reg.control[CTL_LOW_SRCH];
    assign high_temp_search_enable = state_reg.control[CTL_HIGH_SRCH];
    assign lowThreshold            = state_reg.tempLow;
    assign highThreshold           = state_reg.tempHigh;
    assign sampleInterval          = state_reg.sample;

endmodule : logger_rtc_alarm_config

// ---- bench/logger_host_model.sv ----
// Host model that reaches the register page as the link controller would.
`timescale 1ns/1ns
module logger_host_model (
    // Clock
    input  wire logic       sys_clk,
    // Register page access
    output      logic       regWrite = 1'b0,
    output      logic       regRead  = 1'b0,
    output      logic [9:0] regAddr  = 10'h000,
    output      logic [7:0] regWdata = 8'h00,
    input  wire logic [7:0] regRdata,
    input  wire logic       regRvalid
);
    // ------------
    // Bus cycles; an idle bus shows the inverse of the last value.
    // ------------
    task automatic write_reg(input logic [9:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        regAddr  <= ~a;
        regWdata <= ~d;
    endtask : write_reg
    task automatic read_reg(input logic [9:0] a, output logic [7:0] d, output logic ok);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRead <= 1'b0;
        regAddr <= ~a;
        @(posedge sys_clk);
        ok = regRvalid;
        d  = regRdata;
    endtask : read_reg
endmodule : logger_host_model

// ---- bench/logger_rtc_alarm_config_chk.sv ----
// Port-level checks of the logger clock page.
`timescale 1ns/1ns
module logger_rtc_alarm_config_chk
    import logger_rtc_pkg::*;
(
    // Clock and reset
    input wire logic         sys_clk,
    input wire logic         rst_n,
    // Register page and status
    input wire logic         regWrite,
    input wire logic         regRead,
    input wire logic [9:0]   regAddr,
    input wire logic [7:0]   regWdata,
    input wire logic [7:0]   regRdata,
    input wire logic         clear_done_flag,
    input wire logic         missionActive,
    input wire logic         timerFlagClear,
    input wire temp_sample_t tempIn,
    input wire logic         timer_alarm_flag,
    input wire logic         searchTimerMatch,
    input wire logic         missionStart,
    input wire logic         missionEnd,
    input wire logic         oscillatorRunning,
    input wire logic [7:0]   tempCode,
    input wire logic         tempInRange
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire startOk = regWrite && regAddr == OFS_SAMPLE && regWdata != 8'h00 && clear_done_flag && !missionActive;
    chk_ctl_bit5: assert property (regRead && regAddr == OFS_CONTROL |=> !regRdata[5])
        else $error("control bit 5 read as one");
    chk_weekday_zeros: assert property (regRead && regAddr == OFS_WEEKDAY |=> regRdata[7:3] == 5'h00)
        else $error("weekday high bits not zero");
    chk_search_flag: assert property (searchTimerMatch |-> timer_alarm_flag)
        else $error("search match without alarm flag");
    chk_flag_sticky: assert property (timer_alarm_flag && !timerFlagClear |=> timer_alarm_flag)
        else $error("alarm flag dropped");
    chk_start_cause: assert property (missionStart |-> $past(startOk))
        else $error("mission start without cause");
    chk_ctl_ends: assert property (regWrite && regAddr == OFS_CONTROL && missionActive |=> missionEnd)
        else $error("control write did not end mission");
    chk_osc_follow: assert property (regWrite && regAddr == OFS_CONTROL
        |=> oscillatorRunning != $past(regWdata[7])) else $error("oscillator state wrong");
    chk_temp_limit: assert property (tempIn.valid && (tempIn.under || tempIn.over)
        |=> tempCode == ($past(tempIn.under) ? 8'h00 : 8'hFF)) else $error("out of range code wrong");
    chk_temp_range: assert property (tempInRange == (tempCode >= 8'h04 && tempCode <= 8'hFB))
        else $error("range flag wrong");
endmodule : logger_rtc_alarm_config_chk
bind logger_rtc_alarm_config logger_rtc_alarm_config_chk chk_u (.*);

// ---- bench/logger_rtc_alarm_config_tb_top.sv ----
// Self-checking bench of the logger clock page.
`timescale 1ns/1ns
module logger_rtc_alarm_config_tb_top;
    import logger_rtc_pkg::*;
    logic         sys_clk, rst_n, regWrite, regRead, regRvalid, clear_done_flag, missionActive, timerFlagClear;
    logic         timer_alarm_flag, searchTimerMatch, missionStart, missionEnd, oscillatorRunning, tempInRange;
    logic [9:0]   regAddr;
    logic [7:0]   regWdata, regRdata, tempCode, lowThreshold, highThreshold, sampleInterval;
    logic [3:0]   ctlBits;
    temp_sample_t tempIn;
    int           n_fail = 0, n_compared = 0, cycles = 0;
    logger_rtc_alarm_config #(.TICKS_PER_SECOND(10)) dut_u (.*, .wipe_arm(ctlBits[3]), .wrap_logging_enable(ctlBits[2]),
        .low_temp_search_enable(ctlBits[1]), .high_temp_search_enable(ctlBits[0]));
    logger_host_model host_u (.*);
    // ------------
    // Shared checks and sequences
    // ------------
    task automatic check(input string what, input logic [7:0] expv, input logic [7:0] got);
        n_compared++;
        if (got !== expv) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, expv, got);
        end
    endtask : check
    task automatic rd(input logic [9:0] a, input logic [7:0] expv);
        logic [7:0] d;
        logic       ok;
        host_u.read_reg(a, d, ok);
        check("read valid", 8'h01, {7'h00, ok});
        check($sformatf("read %h", a), expv, d);
    endtask : rd
    function automatic logic [7:0] read_mask(input logic [9:0] a);
        case (a)
            OFS_SECONDS, OFS_MINUTES, OFS_HOURS: return 8'h7F;
            OFS_WEEKDAY: return 8'h07;
            OFS_DATE: return 8'h3F;
            OFS_MONTHS: return 8'h9F;
            OFS_ALM_WDAY: return 8'h87;
            default: return (a > OFS_CONTROL) ? 8'h00 : 8'hFF;
        endcase
    endfunction : read_mask
    // Loads a time, lets one second pass and stops the clock again.
    task automatic one_second(input clock_regs_t t, input logic [7:0] ctl);
        logic [7:0] d;
        logic       ok;
        host_u.write_reg(OFS_CONTROL, 8'h80 | ctl);
        timerFlagClear <= 1'b1;
        @(posedge sys_clk);
        timerFlagClear <= 1'b0;
        for (int i = 0; i < 7; i++) host_u.write_reg(OFS_SECONDS + 10'(i), t[55-8*i -: 8]);
        host_u.write_reg(OFS_CONTROL, ctl);
        d = t.seconds;
        for (int i = 0; i < 40 && d == t.seconds; i++) host_u.read_reg(OFS_SECONDS, d, ok);
        host_u.write_reg(OFS_CONTROL, 8'h80 | ctl);
    endtask : one_second
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end
    // ------------
    // Main sequence
    // ------------
    initial begin
        clock_regs_t st [6], ex [6];
        logic [7:0]  tg [4], cn [4], v, e;
        st = '{56'h59_5923_0728_0296, 56'h59_5923_0328_0200, 56'h59_5923_0328_0299,
               56'h59_5923_0131_1299, 56'h59_5971_0631_9299, 56'h59_5919_0510_0421};
        ex = '{56'h00_0000_0129_0296, 56'h00_0000_0429_0200, 56'h00_0000_0401_0399,
               56'h00_0000_0201_8100, 56'h00_0052_0701_0100, 56'h00_0020_0510_0421};
        tg = '{8'h31, 8'h20, 8'h10, 8'h03};
        cn = '{8'h03, 8'h04, 8'hFB, 8'hFC};
        rst_n = 1'b0;
        clear_done_flag = 1'b0;
        missionActive = 1'b0;
        timerFlagClear = 1'b0;
        tempIn = '0;
        void'($urandom(85));
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(OFS_CONTROL, 8'h10);
        rd(OFS_WEEKDAY, 8'h01);
        host_u.write_reg(OFS_CONTROL, 8'hFF);
        rd(OFS_CONTROL, 8'hDF);
        check("ctl outs", 8'h1E, {3'h0, ctlBits, oscillatorRunning});
        for (int i = 0; i < 16; i++) begin
            v = 8'($urandom);
            if (i != 14) host_u.write_reg(OFS_SECONDS + 10'(i), v);
            if (i != 14) rd(OFS_SECONDS + 10'(i), v & read_mask(OFS_SECONDS + 10'(i)));
            if (i == 11 || i == 12) check("threshold", v, (i == 11) ? lowThreshold : highThreshold);
        end
        $display("test registers done");
        // The fifth row loads a date in 2099, so the century flag is written as one.
        for (int r = 0; r < 6; r++) begin
            one_second(st[r], 8'h00);
            for (int i = 0; i < 7; i++) rd(OFS_SECONDS + 10'(i), ex[r][55-8*i -: 8]);
        end
        $display("test calendar done");
        for (int k = 0; k < 5; k++) begin
            for (int h = 1; h >= (k == 0 ? 1 : 0); h--) begin
                for (int j = 0; j < 4; j++) begin
                    v = (j < k) ? tg[j] + 8'((j == k - 1) && h == 0) : 8'h80 | 8'($urandom % 128);
                    host_u.write_reg(OFS_ALM_SEC + 10'(j), v);
                end
                one_second(56'h30_2010_0301_0121, 8'(k != 2));
                check("alarm flag", 8'(h), {7'h00, timer_alarm_flag});
                check("search match", 8'(h && k != 2), {7'h00, searchTimerMatch});
            end
        end
        $display("test alarm done");
        for (int i = 0; i < 4; i++) begin
            v = (i == 2) ? 8'h00 : 8'(($urandom % 255) + 1);
            clear_done_flag <= (i != 1);
            host_u.write_reg(OFS_CONTROL, (i == 3) ? 8'h90 : 8'h80);
            host_u.write_reg(OFS_SAMPLE, v);
            #1;
            check("mission start", 8'(i == 0), {7'h00, missionStart});
            check("interval", v, sampleInterval);
        end
        @(posedge sys_clk);
        missionActive <= 1'b1;
        host_u.write_reg(OFS_CONTROL, 8'h80);
        #1;
        check("mission end", 8'h01, {7'h00, missionEnd});
        @(posedge sys_clk);
        missionActive <= 1'b0;
        $display("test mission done");
        for (int i = 0; i < 24; i++) begin
            v = (i < 4) ? cn[i] : 8'($urandom);
            @(posedge sys_clk);
            tempIn <= '{1'b1, i % 6 == 4, i % 6 == 5, v};
            @(posedge sys_clk);
            tempIn.valid <= 1'b0;
            #1;
            e = (i % 6 == 4) ? 8'h00 : (i % 6 == 5) ? 8'hFF : v;
            check("temp code", e, tempCode);
            check("temp range", 8'(e >= 8'h04 && e <= 8'hFB), {7'h00, tempInRange});
        end
        $display("test temperature done");
        final_report();
    end
endmodule : logger_rtc_alarm_config_tb_top
